/* mrw_pkg.sv */
package mrw_pkg;
	// function codes handled here
	localparam logic [7:0] FC_READ_COILS = 8'h01;
	localparam logic [7:0] FC_WRITE_COIL = 8'h05;
	localparam logic [7:0] FC_DIAG = 8'h08;
	localparam logic [7:0] FC_WRITE_REGS = 8'h10;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] SUB_BAD_FC = 8'h01;
	localparam logic [7:0] SUB_BAD_ADDR = 8'h02;
	localparam logic [7:0] SUB_BAD_DATA = 8'h03;
	localparam logic [7:0] SUB_NONE = 8'h00;
	localparam logic [7:0] BCAST_STATION = 8'h00;
	localparam logic [7:0] STATION_RST = 8'h01;
	// field limits
	localparam logic [7:0] PARAM_NUM_MAX = 8'h63;
	localparam logic [15:0] REG_CNT_MIN = 16'h0001;
	localparam logic [15:0] REG_CNT_MAX = 16'h0032;
	localparam logic [15:0] COIL_ADDR_LIMIT = 16'h0050;
	localparam logic [15:0] COIL_CNT_MAX = 16'h0050;
	localparam logic [15:0] WCOIL_ADDR_LIMIT = 16'h0010;
	localparam logic [15:0] COIL_ON = 16'hff00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	localparam logic [15:0] DIAG_SUB = 16'h0000;
	localparam logic [15:0] RUN_CMD_MASK = 16'he1ff;
	// frame layout, bytes without the error check
	localparam logic [7:0] FIXED_LEN = 8'h06;
	localparam logic [8:0] REGS_HDR_LEN = 9'h007;
	localparam logic [6:0] POS_DATA = 7'h07;
	localparam logic [3:0] EXC_LEN = 4'h3;
	localparam logic [3:0] ECHO_LEN = 4'h6;
	localparam logic [3:0] RD_HDR_LEN = 4'h3;
	localparam int BUF_DEPTH = 128;
	// register map
	localparam logic [7:0] ADDR_STATION = 8'h00;
	localparam logic [7:0] ADDR_RUN_CMD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_CRC_ERR = 8'h0c;
	localparam int STAT_BUSY_BIT = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_EXEC = 3'b001,
		ST_PADDR = 3'b010,
		ST_PCHK = 3'b011,
		ST_SEND = 3'b100
	} mrw_state_type;
endpackage : mrw_pkg

/* mrw_handler.sv */
`timescale 1ns/100ps
module mrw_handler
	import mrw_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset
	input wire logic [7:0] rx_data, // received byte
	input wire logic rx_valid, // byte strobe
	input wire logic rx_last, // last byte of frame
	input wire logic rx_crc_ok, // check result, with rx_last
	output logic [7:0] tx_data, // response byte
	output logic tx_valid, // response byte valid
	output logic tx_last, // last response byte
	input wire logic tx_ready, // framer takes byte
	output logic [15:0] param_addr, // parameter identifier
	output logic [15:0] param_wdata, // parameter write word
	output logic param_wr, // parameter write pulse
	input wire logic param_used, // identifier exists
	input wire logic param_data_ok, // word in range
	output logic [15:0] run_command_word, // run command coils
	input wire logic [15:0] run_status_word, // coils 17-32
	input wire logic [15:0] run_status_word_two, // coils 33-48
	input wire logic [15:0] final_run_command_word, // coils 49-64
	input wire logic [15:0] output_terminal_word, // coils 65-80
	input wire logic [7:0] awaddr, // axi write address
	input wire logic awvalid, // axi
	output logic awready, // axi
	input wire logic [31:0] wdata, // axi write data
	input wire logic [3:0] wstrb, // axi byte strobes
	input wire logic wvalid, // axi
	output logic wready, // axi
	output logic [1:0] bresp, // axi
	output logic bvalid, // axi
	input wire logic bready, // axi
	input wire logic [7:0] araddr, // axi read address
	input wire logic arvalid, // axi
	output logic arready, // axi
	output logic [31:0] rdata, // axi read data
	output logic [1:0] rresp, // axi
	output logic rvalid, // axi
	input wire logic rready // axi
);
	mrw_state_type state_r;
	logic [7:0] mem [0:BUF_DEPTH-1];
	logic [6:0] wr_ptr_r;
	logic ovf_r;
	logic [7:0] frame_len_r;
	logic [7:0] station_r;
	logic [15:0] run_cmd_r;
	logic [15:0] crc_err_r;
	logic exc_r;
	logic [7:0] sub_r;
	logic [7:0] last_sub_r;
	logic [3:0] resp_len_r;
	logic [3:0] rd_bytes_r;
	logic [79:0] coil_r;
	logic [5:0] idx_r;
	logic [7:0] num_r;
	logic [3:0] tx_idx_r;
	logic aw_ok_r;
	logic w_ok_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic do_wr;
	logic [7:0] st, fc;
	logic [15:0] a16, b16;
	logic bcast, ours;
	logic dec_drop, dec_exc, dec_param;
	logic [7:0] dec_sub;
	logic [79:0] coil_map;
	logic [127:0] cnt_mask;
	logic [79:0] coil_sel;
	logic [3:0] rd_bytes;
	logic unused_w;
	logic last_word;
	logic [7:0] tx_byte;
	logic [6:0] wpos;

	assign st = mem[0];
	assign fc = mem[1];
	assign a16 = {mem[2], mem[3]};
	assign b16 = {mem[4], mem[5]};
	assign bcast = (st == BCAST_STATION);
	assign ours = (st == station_r) || bcast;
	assign do_wr = aw_ok_r && w_ok_r && !bvalid;

	// coil image, coil 1 at bit 0
	assign coil_map = {output_terminal_word, final_run_command_word & RUN_CMD_MASK,
		run_status_word_two, run_status_word, run_cmd_r & RUN_CMD_MASK};
	assign cnt_mask = ~({128{1'b1}} << b16[6:0]);
	assign coil_sel = 80'(({48'h0, coil_map} >> a16[6:0]) & cnt_mask);
	assign rd_bytes = 4'((b16[6:0] + 7'h07) >> 3);

	// query checks, in subcode priority order
	always_comb begin
		dec_drop = 1'b0;
		dec_exc = 1'b0;
		dec_param = 1'b0;
		dec_sub = SUB_NONE;
		if (!ours || (bcast && fc != FC_WRITE_REGS)) begin
			dec_drop = 1'b1;
		end else begin
			case (fc)
				FC_WRITE_REGS: begin
					if ({1'b0, frame_len_r} != REGS_HDR_LEN + {1'b0, mem[6]}) begin
						dec_drop = 1'b1;
					end else if (b16 < REG_CNT_MIN || b16 > REG_CNT_MAX
						|| {8'h00, mem[6]} != {b16[14:0], 1'b0}
						|| mem[3] > PARAM_NUM_MAX) begin
						dec_exc = 1'b1;
						dec_sub = SUB_BAD_ADDR;
					end else begin
						dec_param = 1'b1;
					end
				end
				FC_DIAG: begin
					if (frame_len_r != FIXED_LEN) begin
						dec_drop = 1'b1;
					end else if (a16 != DIAG_SUB) begin
						dec_exc = 1'b1;
						dec_sub = SUB_BAD_ADDR;
					end
				end
				FC_READ_COILS: begin
					if (frame_len_r != FIXED_LEN) begin
						dec_drop = 1'b1;
					end else if (a16 >= COIL_ADDR_LIMIT || b16 == 16'h0000
						|| b16 > COIL_CNT_MAX) begin
						dec_exc = 1'b1;
						dec_sub = SUB_BAD_ADDR;
					end
				end
				FC_WRITE_COIL: begin
					if (frame_len_r != FIXED_LEN) begin
						dec_drop = 1'b1;
					end else if (a16 >= WCOIL_ADDR_LIMIT) begin
						dec_exc = 1'b1;
						dec_sub = SUB_BAD_ADDR;
					end else if (b16 != COIL_ON && b16 != COIL_OFF) begin
						dec_exc = 1'b1;
						dec_sub = SUB_BAD_DATA;
					end
				end
				default: begin
					dec_exc = 1'b1;
					dec_sub = SUB_BAD_FC;
				end
			endcase
		end
	end

	assign unused_w = !param_used || num_r > PARAM_NUM_MAX;
	assign last_word = ({10'h000, idx_r} == b16 - REG_CNT_MIN);
	assign wpos = 7'(POS_DATA + {idx_r, 1'b0});

	// receive buffer
	always_ff @(posedge aclk) begin
		if (state_r == ST_IDLE && rx_valid && !ovf_r) begin
			mem[wr_ptr_r] <= rx_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= 7'h00;
			ovf_r <= 1'b0;
			frame_len_r <= 8'h00;
		end else if (state_r == ST_IDLE && rx_valid) begin
			if (rx_last) begin
				wr_ptr_r <= 7'h00;
				ovf_r <= 1'b0;
				frame_len_r <= {1'b0, wr_ptr_r} + 8'h01;
			end else begin
				wr_ptr_r <= wr_ptr_r + 7'h01;
				if (wr_ptr_r == 7'h7f) begin
					ovf_r <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_err_r <= 16'h0000;
		end else if (state_r == ST_IDLE && rx_valid && rx_last && !rx_crc_ok) begin
			crc_err_r <= crc_err_r + 16'h0001;
		end
	end

	// command sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			exc_r <= 1'b0;
			sub_r <= SUB_NONE;
			resp_len_r <= ECHO_LEN;
			rd_bytes_r <= 4'h0;
			coil_r <= 80'h0;
			idx_r <= 6'h00;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (rx_valid && rx_last && rx_crc_ok && !ovf_r) begin
						state_r <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					exc_r <= dec_exc;
					sub_r <= dec_sub;
					idx_r <= 6'h00;
					rd_bytes_r <= rd_bytes;
					coil_r <= coil_sel;
					if (dec_exc) begin
						resp_len_r <= EXC_LEN;
					end else if (fc == FC_READ_COILS) begin
						resp_len_r <= RD_HDR_LEN + rd_bytes;
					end else begin
						resp_len_r <= ECHO_LEN;
					end
					if (dec_drop || (dec_exc && bcast)) begin
						state_r <= ST_IDLE;
					end else if (dec_param) begin
						state_r <= ST_PADDR;
					end else begin
						state_r <= ST_SEND;
					end
				end
				ST_PADDR: begin
					state_r <= ST_PCHK;
				end
				ST_PCHK: begin
					if ((unused_w && idx_r == 6'h00) || (!unused_w && !param_data_ok)) begin
						exc_r <= 1'b1;
						sub_r <= unused_w ? SUB_BAD_ADDR : SUB_BAD_DATA;
						resp_len_r <= EXC_LEN;
						state_r <= bcast ? ST_IDLE : ST_SEND;
					end else if (last_word) begin
						state_r <= bcast ? ST_IDLE : ST_SEND;
					end else begin
						idx_r <= idx_r + 6'h01;
						state_r <= ST_PADDR;
					end
				end
				ST_SEND: begin
					if (tx_valid && tx_ready && tx_last) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_sub_r <= SUB_NONE;
		end else if (state_r == ST_SEND && tx_valid && tx_ready && tx_last && exc_r) begin
			last_sub_r <= sub_r;
		end
	end

	// parameter store port
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			param_addr <= 16'h0000;
			param_wdata <= 16'h0000;
			param_wr <= 1'b0;
			num_r <= 8'h00;
		end else begin
			param_wr <= 1'b0;
			if (state_r == ST_PADDR) begin
				num_r <= mem[3] + {2'b00, idx_r};
				param_addr <= {mem[2], mem[3] + {2'b00, idx_r}};
				param_wdata <= {mem[wpos], mem[wpos + 7'h01]};
			end
			if (state_r == ST_PCHK && !unused_w && param_data_ok) begin
				param_wr <= 1'b1;
			end
		end
	end

	// response byte for the current index
	always_comb begin
		tx_byte = mem[tx_idx_r];
		if (exc_r) begin
			if (tx_idx_r == 4'h1) begin
				tx_byte = fc | EXC_FLAG;
			end else if (tx_idx_r == 4'h2) begin
				tx_byte = sub_r;
			end
		end else if (fc == FC_READ_COILS && tx_idx_r >= 4'h2) begin
			if (tx_idx_r == 4'h2) begin
				tx_byte = {4'h0, rd_bytes_r};
			end else begin
				tx_byte = 8'(coil_r >> {tx_idx_r - RD_HDR_LEN, 3'b000});
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_idx_r <= 4'h0;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_last <= 1'b0;
		end else if (state_r != ST_SEND) begin
			tx_idx_r <= 4'h0;
			tx_valid <= 1'b0;
			tx_last <= 1'b0;
		end else if (!tx_valid) begin
			tx_valid <= 1'b1;
			tx_data <= tx_byte;
			tx_last <= (tx_idx_r == resp_len_r - 4'h1);
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
			tx_last <= 1'b0;
			tx_idx_r <= tx_idx_r + 4'h1;
		end
	end

	// run command coils
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_cmd_r <= 16'h0000;
		end else if (state_r == ST_EXEC && !dec_drop && !dec_exc && fc == FC_WRITE_COIL) begin
			run_cmd_r[a16[3:0]] <= (b16 == COIL_ON) & RUN_CMD_MASK[a16[3:0]];
		end else if (do_wr && awaddr_r == ADDR_RUN_CMD) begin
			if (wstrb_r[0]) begin
				run_cmd_r[7:0] <= wdata_r[7:0] & RUN_CMD_MASK[7:0];
			end
			if (wstrb_r[1]) begin
				run_cmd_r[15:8] <= wdata_r[15:8] & RUN_CMD_MASK[15:8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_command_word <= 16'h0000;
		end else begin
			run_command_word <= run_cmd_r & RUN_CMD_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			station_r <= STATION_RST;
		end else if (do_wr && awaddr_r == ADDR_STATION && wstrb_r[0]) begin
			station_r <= wdata_r[7:0];
		end
	end

	// axi4-lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awready && awvalid) begin
				awaddr_r <= awaddr;
				aw_ok_r <= 1'b1;
				awready <= 1'b0;
			end
			if (wready && wvalid) begin
				wdata_r <= wdata;
				wstrb_r <= wstrb;
				w_ok_r <= 1'b1;
				wready <= 1'b0;
			end
			if (do_wr) begin
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (awaddr_r == ADDR_STATION || awaddr_r == ADDR_RUN_CMD
					|| awaddr_r == ADDR_STATUS || awaddr_r == ADDR_CRC_ERR)
					? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// axi4-lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else if (arready && arvalid) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			case (araddr)
				ADDR_STATION: rdata <= {24'h0, station_r};
				ADDR_RUN_CMD: rdata <= {16'h0, run_cmd_r};
				ADDR_STATUS: begin
					rdata <= {24'h0, last_sub_r};
					rdata[STAT_BUSY_BIT] <= (state_r != ST_IDLE);
				end
				ADDR_CRC_ERR: rdata <= {16'h0, crc_err_r};
				default: begin
					rdata <= 32'h0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule : mrw_handler

/* mrw_handler_sva.sv */
`timescale 1ns/100ps
module mrw_handler_sva
	import mrw_pkg::*;
(
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic [7:0] rx_data, // rx byte
	input wire logic rx_valid, // rx strobe
	input wire logic rx_last, // rx end
	input wire logic rx_crc_ok, // check flag
	input wire logic [7:0] tx_data, // tx byte
	input wire logic tx_valid, // tx valid
	input wire logic tx_last, // tx end
	input wire logic tx_ready, // tx taken
	input wire logic [15:0] param_addr, // identifier
	input wire logic param_wr, // write pulse
	input wire logic param_used, // exists
	input wire logic param_data_ok, // in range
	input wire logic [15:0] run_command_word // coils 1-16
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] rx_idx_r, st_r, fc_r, tx_idx_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) rx_idx_r <= 8'h00;
		else if (rx_valid) rx_idx_r <= rx_last ? 8'h00 : rx_idx_r + 8'h01;
	end
	// station and function of the frame in flight
	always_ff @(posedge aclk) begin
		if (rx_valid && rx_idx_r == 8'h00) st_r <= rx_data;
		if (rx_valid && rx_idx_r == 8'h01) fc_r <= rx_data;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) tx_idx_r <= 8'h00;
		else if (tx_valid && tx_ready) tx_idx_r <= tx_last ? 8'h00 : tx_idx_r + 8'h01;
	end
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte dropped");
	tx_gap_a: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("no idle cycle");
	reply_station_a: assert property (
		tx_valid && tx_idx_r == 8'h00 |-> tx_data == st_r) else $error("bad station");
	reply_func_a: assert property (
		tx_valid && tx_idx_r == 8'h01 |-> tx_data == fc_r || tx_data == (fc_r | EXC_FLAG))
		else $error("bad function");
	bcast_quiet_a: assert property (
		rx_valid && rx_last && st_r == BCAST_STATION |=> !tx_valid [*8])
		else $error("broadcast answered");
	crc_drop_a: assert property (
		rx_valid && rx_last && !rx_crc_ok |=> !tx_valid [*8]) else $error("bad frame answered");
	wr_pulse_a: assert property (param_wr |=> !param_wr) else $error("long pulse");
	wr_checked_a: assert property (
		param_wr |-> $past(param_used) && $past(param_data_ok)) else $error("unchecked write");
	wr_number_a: assert property (
		param_wr |-> param_addr[7:0] <= PARAM_NUM_MAX) else $error("number over 99");
	cmd_reserved_a: assert property (
		(run_command_word & ~RUN_CMD_MASK) == 16'h0000) else $error("reserved coil set");
	cover property (rx_valid && rx_last && st_r == BCAST_STATION);
	cover property (param_wr);
	cover property (tx_valid && tx_idx_r == 8'h01 && tx_data[7]);
endmodule : mrw_handler_sva

/* mrw_host.sv */
`timescale 1ns/100ps
module mrw_host (
	input wire logic aclk, // clock
	input wire logic slow, // stall replies
	output logic [7:0] rx_data = 8'h00, // byte out
	output logic rx_valid = 1'b0, // strobe
	output logic rx_last = 1'b0, // frame end
	output logic rx_crc_ok = 1'b0, // check flag
	input wire logic [7:0] tx_data, // reply byte
	input wire logic tx_valid, // reply valid
	input wire logic tx_last, // reply end
	output logic tx_ready = 1'b0 // reply taken
);
	logic [7:0] rsp[$];
	int ends = 0;
	task automatic send(input logic [7:0] f[$], input logic ok);
		foreach (f[i]) begin
			@(posedge aclk);
			rx_data <= f[i];
			rx_valid <= 1'b1;
			rx_last <= (i == f.size() - 1);
			rx_crc_ok <= ok;
		end
		@(posedge aclk);
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		rx_data <= ~rx_data;
	endtask : send
	always @(posedge aclk) begin
		if (tx_valid && tx_ready) begin
			rsp.push_back(tx_data);
			if (tx_last) ends <= ends + 1;
		end
		tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
	end
endmodule : mrw_host

/* mrw_handler_tb.sv */
`timescale 1ns/100ps
module mrw_handler_tb;
	import mrw_pkg::*;
	typedef logic [7:0] mrw_bytes_type[$];
	localparam logic [7:0] UNUSED_NUM = 8'h05;
	localparam logic [7:0] ST = 8'h05;
	logic aclk, aresetn = 1'b0, slow = 1'b0, rx_valid, rx_last, rx_crc_ok, tx_valid, tx_last;
	logic tx_ready, param_wr, param_used, param_data_ok, awready, wready, bvalid, arready, rvalid;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] rx_data, tx_data, awaddr = 8'h00, araddr = 8'h00;
	logic [15:0] param_addr, param_wdata, run_command_word, cmd_m = 16'h0000;
	logic [15:0] rsw = 16'h0000, rsw2 = 16'h0000, frcw = 16'h0000, otw = 16'h0000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp;
	logic [15:0] wv[51];
	logic [31:0] pw[$];
	mrw_bytes_type none;
	int failures = 0;
	int check_count = 0;
	assign param_used = param_addr[7:0] != UNUSED_NUM;
	assign param_data_ok = param_wdata != 16'hdead;
	always @(posedge aclk) if (param_wr) pw.push_back({param_addr, param_wdata});
	mrw_handler dut_u (.aclk, .aresetn, .rx_data, .rx_valid, .rx_last, .rx_crc_ok, .tx_data,
		.tx_valid, .tx_last, .tx_ready, .param_addr, .param_wdata, .param_wr, .param_used,
		.param_data_ok, .run_command_word, .run_status_word(rsw), .run_status_word_two(rsw2),
		.final_run_command_word(frcw), .output_terminal_word(otw), .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);
	mrw_host host_u (.aclk, .slow, .rx_data, .rx_valid, .rx_last, .rx_crc_ok, .tx_data,
		.tx_valid, .tx_last, .tx_ready);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	function automatic mrw_bytes_type f6(input logic [7:0] st, fc, input logic [15:0] a, b);
		return '{st, fc, a[15:8], a[7:0], b[15:8], b[7:0]};
	endfunction : f6
	function automatic mrw_bytes_type exc(input logic [7:0] fc, sub);
		return '{ST, fc | EXC_FLAG, sub};
	endfunction : exc
	function automatic mrw_bytes_type fregs(input logic [7:0] st, input logic [15:0] id, cnt,
		input logic [7:0] bc);
		mrw_bytes_type r;
		r = f6(st, FC_WRITE_REGS, id, cnt);
		r.push_back(bc);
		for (int i = 0; i < bc; i++) r.push_back(i % 2 ? wv[i / 2][7:0] : wv[i / 2][15:8]);
		return r;
	endfunction : fregs
	function automatic mrw_bytes_type rdexp(input logic [15:0] a, n);
		mrw_bytes_type r;
		logic [79:0] cv;
		cv = {otw, frcw & RUN_CMD_MASK, rsw2, rsw, cmd_m};
		r = '{ST, FC_READ_COILS, 8'((n + 16'h0007) / 16'h0008)};
		for (int i = 0; i < n; i++) begin
			if (i % 8 == 0) r.push_back(8'h00);
			if (int'(a) + i < 80) r[r.size() - 1][i % 8] = cv[int'(a) + i];
		end
		return r;
	endfunction : rdexp
	task automatic xact(input mrw_bytes_type f, input logic ok, input mrw_bytes_type e);
		int n0, k0, i;
		n0 = host_u.rsp.size();
		k0 = host_u.ends;
		host_u.send(f, ok);
		for (i = 0; i < 400 && host_u.ends == k0; i++) @(posedge aclk);
		repeat (4) @(posedge aclk);
		check(32'(host_u.rsp.size() - n0), 32'(e.size()));
		if (host_u.rsp.size() - n0 == e.size())
			foreach (e[j]) check(host_u.rsp[n0 + j], e[j]);
	endtask : xact
	task automatic coil_wr(input logic [7:0] st, input logic [15:0] ad, input logic on);
		mrw_bytes_type f;
		f = f6(st, FC_WRITE_COIL, ad, on ? COIL_ON : COIL_OFF);
		if (st == ST) begin
			cmd_m[ad[3:0]] = on;
			cmd_m &= RUN_CMD_MASK;
			xact(f, 1'b1, f);
		end else xact(f, 1'b1, none);
		check(run_command_word, cmd_m);
	endtask : coil_wr
	task automatic regs(input logic [7:0] st, input logic [15:0] id, cnt,
		input logic [7:0] sub, input int stop);
		int n;
		logic [7:0] num;
		mrw_bytes_type e;
		n = pw.size();
		if (st == BCAST_STATION) e = none;
		else if (sub == SUB_NONE) e = f6(st, FC_WRITE_REGS, id, cnt);
		else e = exc(FC_WRITE_REGS, sub);
		xact(fregs(st, id, cnt, 8'(2 * cnt)), 1'b1, e);
		for (int j = 0; j < cnt && j < stop; j++) begin
			num = id[7:0] + 8'(j);
			if (num <= PARAM_NUM_MAX && num != UNUSED_NUM) begin
				check(pw[n], {id[15:8], num, wv[j]});
				n++;
			end
		end
		check(32'(pw.size()), 32'(n));
		$display("test regs %h done", id);
	endtask : regs
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		static logic [7:0] bad[4] = '{8'h03, 8'h06, 8'h0f, 8'h2b};
		static logic [15:0] ok_a[6] = '{16'h0000, 16'h004f, 16'h000d, 16'h004f, 16'h0010,
			16'h0030};
		static logic [15:0] ok_n[6] = '{16'h0050, 16'h0001, 16'h0009, 16'h0050, 16'h0010,
			16'h0020};
		static logic [15:0] bad_a[3] = '{16'h0050, 16'h0000, 16'h0000};
		static logic [15:0] bad_n[3] = '{16'h0001, 16'h0000, 16'h0051};
		mrw_bytes_type f;
		void'($urandom(34809));
		foreach (wv[i]) wv[i] = 16'($urandom) & 16'h7fff;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axi_wr(ADDR_STATION, {24'h0, ST}, r);
		check(r, RESP_OKAY);
		axi_rd(ADDR_STATION, d, r);
		check(d, {24'h0, ST});
		axi_rd(8'h10, d, r);
		check(r, RESP_SLVERR);
		$display("test registers done");
		repeat (4) begin
			f = f6(ST, FC_DIAG, DIAG_SUB, 16'($urandom));
			xact(f, 1'b1, f);
		end
		xact(f6(ST, FC_DIAG, 16'h0001, 16'h1234), 1'b1, exc(FC_DIAG, SUB_BAD_ADDR));
		xact(f6(BCAST_STATION, FC_DIAG, DIAG_SUB, 16'h0000), 1'b1, none);
		foreach (bad[i]) xact(f6(ST, bad[i], 16'h0, 16'h1), 1'b1, exc(bad[i], SUB_BAD_FC));
		$display("test diagnostics done");
		slow <= 1'b1;
		repeat (12) coil_wr(ST, 16'($urandom_range(15)), 1'($urandom));
		coil_wr(ST, 16'h0009, 1'b1);
		coil_wr(ST, 16'h000f, 1'b1);
		coil_wr(BCAST_STATION, 16'h0000, 1'b1);
		xact(f6(ST, FC_WRITE_COIL, WCOIL_ADDR_LIMIT, COIL_ON), 1'b1,
			exc(FC_WRITE_COIL, SUB_BAD_ADDR));
		xact(f6(ST, FC_WRITE_COIL, 16'h0001, 16'h1234), 1'b1,
			exc(FC_WRITE_COIL, SUB_BAD_DATA));
		xact(f6(ST, FC_WRITE_COIL, 16'h0001, COIL_ON), 1'b0, none);
		check(run_command_word, cmd_m);
		axi_rd(ADDR_CRC_ERR, d, r);
		check(d, 32'h00000001);
		axi_rd(ADDR_STATUS, d, r);
		check(d, {24'h0, SUB_BAD_DATA});
		axi_wr(ADDR_RUN_CMD, 32'h0000ffff, r);
		cmd_m = RUN_CMD_MASK;
		axi_rd(ADDR_RUN_CMD, d, r);
		check(d, {16'h0, cmd_m});
		check(run_command_word, cmd_m);
		$display("test coil write done");
		@(posedge aclk);
		rsw <= 16'($urandom);
		rsw2 <= 16'($urandom);
		frcw <= 16'hffff;
		otw <= 16'($urandom);
		@(posedge aclk);
		foreach (ok_a[i]) xact(f6(ST, FC_READ_COILS, ok_a[i], ok_n[i]), 1'b1,
			rdexp(ok_a[i], ok_n[i]));
		repeat (4) begin
			d = {16'($urandom_range(79)), 16'($urandom_range(80, 1))};
			xact(f6(ST, FC_READ_COILS, d[31:16], d[15:0]), 1'b1, rdexp(d[31:16], d[15:0]));
		end
		foreach (bad_a[i]) xact(f6(ST, FC_READ_COILS, bad_a[i], bad_n[i]), 1'b1,
			exc(FC_READ_COILS, SUB_BAD_ADDR));
		xact(f6(BCAST_STATION, FC_READ_COILS, 16'h0, 16'h8), 1'b1, none);
		$display("test coil read done");
		regs(ST, 16'h0100, 16'h0003, SUB_NONE, 99);
		regs(ST, 16'h0203, 16'h0004, SUB_NONE, 99);
		regs(ST, 16'h0361, 16'h0005, SUB_NONE, 99);
		regs(ST, 16'h0000, REG_CNT_MAX, SUB_NONE, 99);
		regs(ST, 16'h0000, 16'h0033, SUB_BAD_ADDR, 0);
		regs(ST, 16'h0000, 16'h0000, SUB_BAD_ADDR, 0);
		regs(ST, 16'h0105, 16'h0002, SUB_BAD_ADDR, 0);
		regs(BCAST_STATION, 16'h0400, 16'h0002, SUB_NONE, 99);
		wv[1] = 16'hdead;
		regs(ST, 16'h0400, 16'h0003, SUB_BAD_DATA, 1);
		xact(fregs(ST, 16'h0100, 16'h0002, 8'h03), 1'b1, exc(FC_WRITE_REGS, SUB_BAD_ADDR));
		$display("test byte count done");
		give_verdict();
	end
	initial begin
		repeat (60000) @(posedge aclk);
		failures++;
		give_verdict();
	end
endmodule : mrw_handler_tb
bind mrw_handler mrw_handler_sva chk_u (.aclk, .aresetn, .rx_data, .rx_valid, .rx_last,
	.rx_crc_ok, .tx_data, .tx_valid, .tx_last, .tx_ready, .param_addr, .param_wr, .param_used,
	.param_data_ok, .run_command_word);
